// [logic/codec_gain_volume_regs.sv]
// Purpose: control and status registers for codec playback and record gain paths
// Assumes: serial framing outside delivers one byte access per strobe
// Notes:   decoded controls follow a write on the same edge the register updates
// Operation
// - left playback volume, 0.375 dB attenuation steps
// - right playback volume, same encoding, independent
// - left playback peak, 6-bit 1 dB code
// - right playback peak, same 6-bit code
// - left input gain 0.5 dB steps, saturates 24 dB
// - right input gain, same steps and saturation
// - modulator clock divide two or four
// - right record mute; high-pass filter enable
// - left record mute, active high
// - record, analog, left and right amplifier power-downs
// - reference buffer power-down when set
// - clock divider codes 1, 2, 3, 1
// - left record volume linear scale
// - right record volume, same scale, independent
// - left record peak, 6-bit 1 dB code
// - right record peak, same code
`timescale 1ns/1ps
module codec_gain_volume_regs
    import codec_regs_pkg::*;
(
    input  wire logic                          i_sys_clk,          // 200 MHz clock
    input  wire logic                          i_resetn,           // async reset, active low
    input  wire logic                          i_wr_en,            // register write strobe
    input  wire logic                          i_rd_en,            // register read strobe
    input  wire logic [codec_regs_pkg::ADDR_W-1:0] i_addr,         // register address
    input  wire logic [codec_regs_pkg::DATA_W-1:0] i_wdata,        // write data
    input  wire logic                          i_dac_level_l_vld,  // playback left level strobe
    input  wire logic [codec_regs_pkg::PEAK_W-1:0] i_dac_level_l,  // playback left level code
    input  wire logic                          i_dac_level_r_vld,  // playback right level strobe
    input  wire logic [codec_regs_pkg::PEAK_W-1:0] i_dac_level_r,  // playback right level code
    input  wire logic                          i_rec_level_l_vld,  // record left level strobe
    input  wire logic [codec_regs_pkg::PEAK_W-1:0] i_rec_level_l,  // record left level code
    input  wire logic                          i_rec_level_r_vld,  // record right level strobe
    input  wire logic [codec_regs_pkg::PEAK_W-1:0] i_rec_level_r,  // record right level code
    output logic      [codec_regs_pkg::DATA_W-1:0] o_rdata,        // read data
    output logic                               o_rd_valid,         // read data valid pulse
    output logic      [7:0]                    o_dac_vol_left,     // playback left volume
    output logic      [7:0]                    o_dac_vol_right,    // playback right volume
    output logic      [5:0]                    o_pga_gain_left,    // left gain, half dB, clamped
    output logic      [5:0]                    o_pga_gain_right,   // right gain, half dB, clamped
    output logic      [2:0]                    o_record_mod_div,   // modulator clock divide
    output logic                               o_highpass_enable,  // record high-pass on
    output logic                               o_record_power_off, // record converter off
    output logic                               o_record_analog_off,// record analog off
    output logic                               o_record_mute_right,// right record muted
    output logic                               o_record_mute_left, // left record muted
    output logic                               o_pga_left_off,     // left amplifier off
    output logic                               o_pga_right_off,    // right amplifier off
    output logic                               o_ref_buffer_off,   // reference buffer off
    output logic      [1:0]                    o_record_clock_div, // divide ratio 1..3
    output logic      [7:0]                    o_record_vol_left,  // record left scale
    output logic      [7:0]                    o_record_vol_right  // record right scale
);
    import codec_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    logic       in_range;
    logic [3:0] idx;
    logic [6:0] rel_addr;

    // offsets are contiguous, so one subtract gives the table index
    assign rel_addr = i_addr - OFS_DAC_VOL_LEFT;
    assign in_range = (i_addr >= OFS_DAC_VOL_LEFT) && (i_addr <= OFS_REC_PEAK_RIGHT);
    assign idx      = rel_addr[3:0];

    ////////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];

    // one write path per register; read-only peaks have an all-zero mask
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        always_comb begin
            regs_d[g] = regs_q[g];
            if (i_wr_en && in_range && (idx == 4'(g))) begin
                regs_d[g] = i_wdata & REG_MASK[g];
            end
        end

        always_ff @(posedge i_sys_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                regs_q[g] <= REG_RESET[g];
            end else begin
                regs_q[g] <= regs_d[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // peak detectors

    logic [PEAK_W-1:0] peak_level [NUM_PEAKS];
    logic [NUM_PEAKS-1:0] peak_vld;
    logic [PEAK_W-1:0] peak_val   [NUM_PEAKS];
    logic [NUM_PEAKS-1:0] peak_clr;

    assign peak_vld      = {i_rec_level_r_vld, i_rec_level_l_vld,
                            i_dac_level_r_vld, i_dac_level_l_vld};
    assign peak_level[0] = i_dac_level_l;
    assign peak_level[1] = i_dac_level_r;
    assign peak_level[2] = i_rec_level_l;
    assign peak_level[3] = i_rec_level_r;

    // a read of a peak register restarts that detector
    for (genvar p = 0; p < NUM_PEAKS; p++) begin : g_peak
        assign peak_clr[p] = i_rd_en && in_range && (idx == PEAK_IDX[p]);

        peak_hold #(
            .W(PEAK_W)
        ) u_peak (
            .i_sys_clk (i_sys_clk),
            .i_resetn  (i_resetn),
            .i_valid   (peak_vld[p]),
            .i_level   (peak_level[p]),
            .i_clear   (peak_clr[p]),
            .o_peak    (peak_val[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rd_valid_q;
    logic       rd_valid_d;

    // peaks read through the low six bits, upper bits zero; unmapped reads zero
    always_comb begin
        rdata_d    = rdata_q;
        rd_valid_d = i_rd_en;
        if (i_rd_en) begin
            rdata_d = 8'h00;
            if (in_range) begin
                case (idx)
                    4'h2:    rdata_d = {2'b00, peak_val[0]};
                    4'h3:    rdata_d = {2'b00, peak_val[1]};
                    4'ha:    rdata_d = {2'b00, peak_val[2]};
                    4'hb:    rdata_d = {2'b00, peak_val[3]};
                    default: rdata_d = regs_q[idx];
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q    <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded controls

    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [5:0] gain_l_d;
    logic [5:0] gain_r_d;
    logic [2:0] mod_div_d;
    logic [1:0] clk_div_d;
    logic [5:0] gain_l_q;
    logic [5:0] gain_r_q;
    logic [2:0] mod_div_q;
    logic [1:0] clk_div_q;
    logic [7:0] flags_q;

    assign ctl1 = regs_d[6];
    assign ctl2 = regs_d[7];

    // gain codes past 24 dB saturate; divider code three falls back to one
    always_comb begin
        gain_l_d  = (regs_d[4][5:0] > GAIN_MAX_CODE) ? GAIN_MAX_CODE : regs_d[4][5:0];
        gain_r_d  = (regs_d[5][5:0] > GAIN_MAX_CODE) ? GAIN_MAX_CODE : regs_d[5][5:0];
        mod_div_d = ctl1[MOD_CLK_BIT] ? MOD_DIV_SLOW : MOD_DIV_FAST;
        clk_div_d = ctl2[CLK_DIV_LSB +: 2];
        if (clk_div_d == CLK_DIV_CODE3) begin
            clk_div_d = 2'h1;
        end else begin
            clk_div_d = clk_div_d + 2'h1;
        end
    end

    // controls are decoded from the next register values to avoid a second cycle of lag
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gain_l_q  <= 6'h00;
            gain_r_q  <= 6'h00;
            mod_div_q <= MOD_DIV_FAST;
            clk_div_q <= 2'h1;
            flags_q   <= 8'h00;
        end else begin
            gain_l_q  <= gain_l_d;
            gain_r_q  <= gain_r_d;
            mod_div_q <= mod_div_d;
            clk_div_q <= clk_div_d;
            flags_q   <= {ctl1[6:0], ctl2[BUF_OFF_BIT]};
        end
    end

    assign o_rdata             = rdata_q;
    assign o_rd_valid          = rd_valid_q;
    assign o_dac_vol_left      = regs_q[0];
    assign o_dac_vol_right     = regs_q[1];
    assign o_record_vol_left   = regs_q[8];
    assign o_record_vol_right  = regs_q[9];
    assign o_pga_gain_left     = gain_l_q;
    assign o_pga_gain_right    = gain_r_q;
    assign o_record_mod_div    = mod_div_q;
    assign o_record_clock_div  = clk_div_q;
    assign o_highpass_enable   = flags_q[HIGHPASS_BIT + 1];
    assign o_record_power_off  = flags_q[PWR_OFF_BIT + 1];
    assign o_record_analog_off = flags_q[ANA_OFF_BIT + 1];
    assign o_record_mute_right = flags_q[MUTE_R_BIT + 1];
    assign o_record_mute_left  = flags_q[MUTE_L_BIT + 1];
    assign o_pga_left_off      = flags_q[PGA_L_OFF_BIT + 1];
    assign o_pga_right_off     = flags_q[PGA_R_OFF_BIT + 1];
    assign o_ref_buffer_off    = flags_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    dac_vol_write_a: assert property (
        i_wr_en && (i_addr == OFS_DAC_VOL_LEFT) |=> o_dac_vol_left == $past(i_wdata))
        else $error("playback left volume not updated by write");

    rec_vol_write_a: assert property (
        i_wr_en && (i_addr == OFS_REC_VOL_RIGHT) |=> o_record_vol_right == $past(i_wdata))
        else $error("record right volume not updated by write");

    gain_clamp_a: assert property (
        i_wr_en && (i_addr == OFS_PGA_GAIN_LEFT) && (i_wdata[5:0] >= 6'h30)
        |=> o_pga_gain_left == 6'h30)
        else $error("left gain not saturated at 24 dB");

    gain_pass_a: assert property (
        i_wr_en && (i_addr == OFS_PGA_GAIN_RIGHT) && (i_wdata[5:0] < 6'h30)
        |=> o_pga_gain_right == $past(i_wdata[5:0]))
        else $error("right gain code not passed through");

    mod_div_a: assert property (
        o_record_mod_div == (regs_q[6][7] ? 3'h4 : 3'h2))
        else $error("modulator divide does not follow select bit");

    clock_div_a: assert property (
        i_wr_en && (i_addr == OFS_REC_CTRL_TWO) && (i_wdata[1:0] == 2'h3)
        |=> o_record_clock_div == 2'h1)
        else $error("divider code three must divide by one");

    mute_follow_a: assert property (
        i_wr_en && (i_addr == OFS_REC_CTRL_ONE)
        |=> o_record_mute_left == $past(i_wdata[2]) && o_pga_right_off == $past(i_wdata[0]))
        else $error("record control bits not applied");

    buf_off_a: assert property (
        i_wr_en && (i_addr == OFS_REC_CTRL_TWO) |=> o_ref_buffer_off == $past(i_wdata[4]))
        else $error("reference buffer control not applied");

    reserved_zero_a: assert property (
        o_rd_valid && $past(i_addr == OFS_PGA_GAIN_LEFT) |-> o_rdata[7:6] == 2'b00)
        else $error("reserved gain bits read nonzero");

    rd_valid_a: assert property (
        i_rd_en |=> o_rd_valid ##1 (o_rd_valid == $past(i_rd_en)))
        else $error("read valid does not follow read strobe");

    peak_restart_a: assert property (
        i_rd_en && (i_addr == OFS_REC_PEAK_LEFT) && !i_rec_level_l_vld
        |=> peak_val[2] == 6'h3f)
        else $error("peak not restarted after read");

    peak_hold_a: assert property (
        i_dac_level_l_vld && !peak_clr[0] && (i_dac_level_l < peak_val[0])
        |=> peak_val[0] == $past(i_dac_level_l))
        else $error("louder playback level not captured");

    dac_vol_right_a: assert property (
        i_wr_en && (i_addr == OFS_DAC_VOL_RIGHT) |=> o_dac_vol_right == $past(i_wdata))
        else $error("playback right volume not updated by write");

    rec_vol_left_a: assert property (
        i_wr_en && (i_addr == OFS_REC_VOL_LEFT) |=> o_record_vol_left == $past(i_wdata))
        else $error("record left volume not updated by write");

    // each control bit checked at its own position, so a swapped field is caught
    mute_right_a: assert property (
        i_wr_en && (i_addr == OFS_REC_CTRL_ONE)
        |=> o_record_mute_right == $past(i_wdata[3]) && o_highpass_enable == $past(i_wdata[6]))
        else $error("right mute or high-pass control not applied");

    power_off_a: assert property (
        i_wr_en && (i_addr == OFS_REC_CTRL_ONE)
        |=> o_record_power_off == $past(i_wdata[5]) && o_record_analog_off == $past(i_wdata[4])
            && o_pga_left_off == $past(i_wdata[1]))
        else $error("record power-down controls not applied");

endmodule

// [common/codec_regs_pkg.sv]
// Purpose: shared constants for the record/playback gain and volume register bank
// Assumes: 7-bit register addresses, 8-bit register data, one clock domain
// Notes:   reset values are plain defaults; peak codes count dB below full scale
package codec_regs_pkg;

    localparam int          NUM_REGS    = 12;
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 7;
    localparam int          PEAK_W      = 6;
    localparam int          NUM_PEAKS   = 4;

    // register offsets, one byte each
    localparam logic [6:0]  OFS_DAC_VOL_LEFT   = 7'h68;
    localparam logic [6:0]  OFS_DAC_VOL_RIGHT  = 7'h69;
    localparam logic [6:0]  OFS_DAC_PEAK_LEFT  = 7'h6a;
    localparam logic [6:0]  OFS_DAC_PEAK_RIGHT = 7'h6b;
    localparam logic [6:0]  OFS_PGA_GAIN_LEFT  = 7'h6c;
    localparam logic [6:0]  OFS_PGA_GAIN_RIGHT = 7'h6d;
    localparam logic [6:0]  OFS_REC_CTRL_ONE   = 7'h6e;
    localparam logic [6:0]  OFS_REC_CTRL_TWO   = 7'h6f;
    localparam logic [6:0]  OFS_REC_VOL_LEFT   = 7'h70;
    localparam logic [6:0]  OFS_REC_VOL_RIGHT  = 7'h71;
    localparam logic [6:0]  OFS_REC_PEAK_LEFT  = 7'h72;
    localparam logic [6:0]  OFS_REC_PEAK_RIGHT = 7'h73;

    // writable bits per register, indexed by offset minus the first offset
    localparam logic [7:0]  REG_MASK [NUM_REGS] = '{
        8'hff, 8'hff, 8'h00, 8'h00, 8'h3f, 8'h3f,
        8'hff, 8'h13, 8'hff, 8'hff, 8'h00, 8'h00};
    localparam logic [7:0]  REG_RESET [NUM_REGS] = '{
        8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

    // peak register index for each detector: dac left, dac right, rec left, rec right
    localparam logic [3:0]  PEAK_IDX [NUM_PEAKS] = '{4'h2, 4'h3, 4'ha, 4'hb};

    // record control one fields
    localparam int          MOD_CLK_BIT   = 7;
    localparam int          HIGHPASS_BIT  = 6;
    localparam int          PWR_OFF_BIT   = 5;
    localparam int          ANA_OFF_BIT   = 4;
    localparam int          MUTE_R_BIT    = 3;
    localparam int          MUTE_L_BIT    = 2;
    localparam int          PGA_L_OFF_BIT = 1;
    localparam int          PGA_R_OFF_BIT = 0;
    // record control two fields
    localparam int          BUF_OFF_BIT   = 4;
    localparam int          CLK_DIV_LSB   = 0;

    localparam logic [5:0]  GAIN_MAX_CODE = 6'h30;
    localparam logic [5:0]  PEAK_QUIET    = 6'h3f;
    localparam logic [2:0]  MOD_DIV_SLOW  = 3'h4;
    localparam logic [2:0]  MOD_DIV_FAST  = 3'h2;
    localparam logic [1:0]  CLK_DIV_CODE3 = 2'h3;

endpackage

// [logic/peak_hold.sv]
// Purpose: hold the loudest level code seen since the last clear
// Assumes: level codes count dB below full scale, so smaller is louder
// Notes:   a level arriving with the clear starts the new window
`timescale 1ns/1ps
module peak_hold #(
    parameter int W = 6
) (
    input  wire logic         i_sys_clk,   // system clock
    input  wire logic         i_resetn,    // async reset, active low
    input  wire logic         i_valid,     // level code strobe
    input  wire logic [W-1:0] i_level,     // level code, 0 = full scale
    input  wire logic         i_clear,     // restart detection
    output logic      [W-1:0] o_peak       // held loudest code
);
    logic [W-1:0] peak_q;
    logic [W-1:0] peak_d;

    // the new level wins over a clear in the same cycle so no peak is lost
    always_comb begin
        peak_d = peak_q;
        if (i_valid && i_clear) begin
            peak_d = i_level;
        end else if (i_valid) begin
            peak_d = (i_level < peak_q) ? i_level : peak_q;
        end else if (i_clear) begin
            peak_d = '1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            peak_q <= '1;
        end else begin
            peak_q <= peak_d;
        end
    end

    assign o_peak = peak_q;
endmodule

// [sim/codec_gain_volume_regs_tb_top.sv]
// Purpose: self-checking bench for the codec gain and volume register bank
// Assumes: single 200 MHz clock, one-cycle read latency, peaks clear to quietest on read
// Notes:   inputs move 1 ns after the rising edge so no sample races the drive
`timescale 1ns/1ps
module codec_gain_volume_regs_tb_top
    import codec_regs_pkg::*;
;
    logic              i_sys_clk;
    logic              i_resetn;
    logic              i_wr_en;
    logic              i_rd_en;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic              dl_vld, dr_vld, rl_vld, rr_vld;
    logic [PEAK_W-1:0] dl, dr, rl, rr;
    logic [DATA_W-1:0] o_rdata;
    logic              o_rd_valid;
    logic [7:0]        dvl, dvr, rvl, rvr;
    logic [5:0]        pgl, pgr;
    logic [2:0]        mdiv;
    logic [1:0]        cdiv;
    logic              hpe, pwr, ana, mr, ml, plo, pro, bufo;
    int                fail_count;
    int                n_checks;
    int                cycles;
    logic [7:0]        rd_val;

    codec_gain_volume_regs dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_addr(i_addr), .i_wdata(i_wdata),
        .i_dac_level_l_vld(dl_vld), .i_dac_level_l(dl), .i_dac_level_r_vld(dr_vld),
        .i_dac_level_r(dr), .i_rec_level_l_vld(rl_vld), .i_rec_level_l(rl),
        .i_rec_level_r_vld(rr_vld), .i_rec_level_r(rr),
        .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .o_dac_vol_left(dvl), .o_dac_vol_right(dvr),
        .o_pga_gain_left(pgl), .o_pga_gain_right(pgr), .o_record_mod_div(mdiv),
        .o_highpass_enable(hpe), .o_record_power_off(pwr), .o_record_analog_off(ana),
        .o_record_mute_right(mr), .o_record_mute_left(ml), .o_pga_left_off(plo),
        .o_pga_right_off(pro), .o_ref_buffer_off(bufo), .o_record_clock_div(cdiv),
        .o_record_vol_left(rvl), .o_record_vol_right(rvr));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling is far above the roughly 110 cycles needed
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared compare, bus cycles and verdict
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_wr_en = 1'b1;
        i_addr  = a;
        i_wdata = d;
        @(posedge i_sys_clk);
        #1 i_wr_en = 1'b0;
        // one idle edge so a following write never re-raises the strobe in this time step
        @(posedge i_sys_clk);
        #1;
    endtask

    // read data is looked at in the single cycle that the valid pulse stands
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        i_rd_en = 1'b1;
        i_addr  = a;
        @(posedge i_sys_clk);
        #1 i_rd_en = 1'b0;
        chk("rd_valid", {7'h0, o_rd_valid}, 8'h01);
        d = o_rdata;
        @(posedge i_sys_clk);
        #1 chk("rd_valid_low", {7'h0, o_rd_valid}, 8'h00);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [7:0] exp [12];
        exp = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00,
                8'hff, 8'hff, 8'h3f, 8'h3f};
        for (int i = 0; i < 12; i++) begin
            rd(7'h68 + 7'(i), rd_val);
            chk("reset_read", rd_val, exp[i]);
        end
        chk("mod_div_reset", {5'h0, mdiv}, 8'h02);
        chk("clk_div_reset", {6'h0, cdiv}, 8'h01);
    endtask

    // a different code on each volume register, channels set apart to show independence
    task automatic t_volume();
        wr(7'h68, 8'h00);
        wr(7'h69, 8'h7f);
        wr(7'h70, 8'h40);
        wr(7'h71, 8'hfe);
        chk("dac_vol_left", dvl, 8'h00);
        chk("dac_vol_right", dvr, 8'h7f);
        chk("rec_vol_left", rvl, 8'h40);
        chk("rec_vol_right", rvr, 8'hfe);
        rd(7'h69, rd_val);
        chk("dac_vol_right_rd", rd_val, 8'h7f);
        rd(7'h70, rd_val);
        chk("rec_vol_left_rd", rd_val, 8'h40);
    endtask

    // gain saturates at code 0x30 and upper bits are reserved
    task automatic t_gain();
        wr(7'h6c, 8'hff);
        wr(7'h6d, 8'h2f);
        chk("gain_left_sat", {2'h0, pgl}, 8'h30);
        chk("gain_right", {2'h0, pgr}, 8'h2f);
        rd(7'h6c, rd_val);
        chk("gain_left_rd", rd_val, 8'h3f);
        wr(7'h6d, 8'h30);
        chk("gain_right_edge", {2'h0, pgr}, 8'h30);
        wr(7'h6c, 8'h2f);
        chk("gain_left_top", {2'h0, pgl}, 8'h2f);
    endtask

    // one control bit at a time, so a swapped field shows as a wrong position
    task automatic t_ctrl_one();
        logic [7:0] seen;
        for (int i = 0; i < 8; i++) begin
            wr(7'h6e, 8'h01 << i);
            seen = {mdiv == 3'h4, hpe, pwr, ana, mr, ml, plo, pro};
            chk("ctrl_one_bits", seen, 8'h01 << i);
            chk("mod_div", {5'h0, mdiv}, (i == 7) ? 8'h04 : 8'h02);
        end
        rd(7'h6e, rd_val);
        chk("ctrl_one_rd", rd_val, 8'h80);
    endtask

    task automatic t_ctrl_two();
        logic [7:0] ratio [4];
        ratio = '{8'h01, 8'h02, 8'h03, 8'h01};
        for (int c = 0; c < 4; c++) begin
            wr(7'h6f, 8'hec | 8'(c));
            chk("clk_div", {6'h0, cdiv}, ratio[c]);
            chk("buf_off", {7'h0, bufo}, 8'h00);
        end
        wr(7'h6f, 8'hff);
        chk("buf_off_set", {7'h0, bufo}, 8'h01);
        rd(7'h6f, rd_val);
        chk("ctrl_two_rd", rd_val, 8'h13);
    endtask

    // two strobes per detector; the louder (smaller) code must be held
    task automatic t_peak();
        logic [7:0] exp [4];
        logic [6:0] pa [4];
        exp = '{8'h03, 8'h14, 8'h00, 8'h28};
        pa  = '{7'h6a, 7'h6b, 7'h72, 7'h73};
        wr(7'h6a, 8'h01);
        {dl_vld, dr_vld, rl_vld, rr_vld} = 4'hf;
        {dl, dr, rl, rr} = {6'd10, 6'd20, 6'd30, 6'd40};
        @(posedge i_sys_clk);
        #1 {dl, dr, rl, rr} = {6'd3, 6'd25, 6'd0, 6'd63};
        @(posedge i_sys_clk);
        #1 {dl_vld, dr_vld, rl_vld, rr_vld} = 4'h0;
        for (int i = 0; i < 4; i++) begin
            rd(pa[i], rd_val);
            chk("peak", rd_val, exp[i]);
            rd(pa[i], rd_val);
            chk("peak_cleared", rd_val, 8'h3f);
        end
        wr(7'h72, 8'h00);
        rd(7'h72, rd_val);
        chk("peak_write_ignored", rd_val, 8'h3f);
    endtask

    // unmapped places read zero and a write there disturbs nothing
    task automatic t_unmapped();
        wr(7'h74, 8'h00);
        wr(7'h67, 8'h00);
        rd(7'h74, rd_val);
        chk("unmapped_rd", rd_val, 8'h00);
        chk("vol_kept", dvr, 8'h7f);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        fail_count = 0;
        n_checks   = 0;
        cycles     = 0;
        i_resetn   = 1'b0;
        i_wr_en    = 1'b0;
        i_rd_en    = 1'b0;
        i_addr     = 7'h00;
        i_wdata    = 8'h00;
        {dl_vld, dr_vld, rl_vld, rr_vld} = 4'h0;
        {dl, dr, rl, rr} = 24'h0;
        repeat (6) @(posedge i_sys_clk);
        #1 i_resetn = 1'b1;
        t_reset();
        t_volume();
        t_gain();
        t_ctrl_one();
        t_ctrl_two();
        t_peak();
        t_unmapped();
        end_sim();
    end
endmodule
